// >>> verilog/sgm_cfg.svh
// Register indices, reset values, field positions and timing constants
`ifndef SGM_CFG_SVH
`define SGM_CFG_SVH
`define SGM_CLK_NS 25
`define SGM_IDX_MAIN 14'h0608
`define SGM_IDX_EEE1 14'h0609
`define SGM_IDX_STAT 14'h060A
`define SGM_IDX_QUIET 14'h060B
`define SGM_IDX_CTRL2 14'h060C
`define SGM_IDX_FERR 14'h060D
`define SGM_RST_MAIN 16'h007B
`define SGM_RST_EEE1 16'h0000
`define SGM_RST_QUIET 4'h5
`define SGM_RST_CTRL2 16'h0024
`define SGM_B_TXERR 15
`define SGM_B_IFORCE 14
`define SGM_B_IVAL 10
`define SGM_B_EN 9
`define SGM_B_RXINV 8
`define SGM_B_TXINV 7
`define SGM_B_RXORD 4
`define SGM_B_ALPKT 3
`define SGM_B_ANTIM 1
`define SGM_B_ANEN 0
`define SGM_B_NONEEE 0
`define SGM_B_FVAL 8
`define SGM_B_FCTL 7
`define SGM_B_RESTART 6
`define SGM_B_TXTH 3
`define SGM_B_RXTH 0
`define SGM_AN_T0_NS 1600000
`define SGM_AN_T1_NS 2000
`define SGM_AN_T2_NS 800000
`define SGM_AN_T3_NS 11000000
`define SGM_QUIET_BASE_NS 3100000
`define SGM_QUIET_STEP_NS 100000
`define SGM_SYNC_HITS 2'h3
`define SGM_LOSS_WORDS 8'hFF
`endif

// >>> verilog/sgm_pkg.sv
// Types shared by the serial MAC interface control block
package sgm_pkg;
    typedef struct packed {
        logic sop;
        logic eop;
        logic err;
        logic [7:0] data;
    } sgm_tx_word_t;
    typedef enum logic [1:0] {AL_HUNT = 2'b00, AL_CHECK = 2'b01, AL_SYNC = 2'b10} sgm_align_st_t;
    typedef enum logic [1:0] {AN_OFF = 2'b00, AN_WAIT = 2'b01, AN_TIMER = 2'b10, AN_DONE = 2'b11} sgm_an_st_t;
endpackage

// >>> verilog/sgm_ctrl.sv
// Serial MAC interface control: registers, alignment, negotiation, sync FIFOs
//
// The APB register port was decided locally.
`include "sgm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Sync FIFO
// ----------------------------------------
module sgm_fifo #(parameter int W = 11, parameter int D = 16) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_reg, rd_reg;
    logic [AW:0] cnt_reg;
    logic push, pop;
    assign in_ready = cnt_reg != D[AW:0];
    assign out_valid = cnt_reg != '0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_reg];
    assign level = cnt_reg;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_reg + AW'(push);
            rd_reg <= rd_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module sgm_ctrl #(
    parameter int AN_T0_CYC = `SGM_AN_T0_NS / `SGM_CLK_NS,
    parameter int AN_T2_CYC = `SGM_AN_T2_NS / `SGM_CLK_NS,
    parameter int AN_T3_CYC = `SGM_AN_T3_NS / `SGM_CLK_NS,
    parameter int QUIET_BASE_CYC = `SGM_QUIET_BASE_NS / `SGM_CLK_NS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] strap_rx_data,
    input wire sgm_pkg::sgm_tx_word_t mac_tx,
    input wire logic mac_tx_valid,
    output logic mac_tx_ready,
    output sgm_pkg::sgm_tx_word_t ser_tx,
    output logic ser_tx_valid,
    input wire logic ser_tx_ready,
    input wire logic tx_even,
    input wire logic [9:0] des_rx_word,
    input wire logic des_rx_valid,
    output logic [9:0] mac_rx_word,
    output logic mac_rx_valid,
    input wire logic mac_rx_ready,
    input wire logic an_page_in,
    input wire logic cdr_lock_pin,
    input wire logic rx_lpi_in,
    output logic rx_lpi_to_mac,
    output logic rx_quiet_done,
    output logic tx_fifo_half,
    output logic rx_fifo_half,
    output logic serial_link_up
);
    import sgm_pkg::*;
    localparam int AN_T1_CYC = `SGM_AN_T1_NS / `SGM_CLK_NS;
    localparam int QUIET_STEP_CYC = `SGM_QUIET_STEP_NS / `SGM_CLK_NS;

    logic [15:0] main_reg, eee1_reg, ctrl2_reg;
    logic [3:0] quiet_reg, ferr_reg;
    logic page_reg, restart_reg;
    logic [2:0] strap_s1_reg, strap_s2_reg;
    logic lock_s1_reg, lock_s2_reg;
    sgm_align_st_t al_reg;
    sgm_an_st_t an_reg;
    logic [3:0] al_idx_reg, sel_idx;
    logic [1:0] hits_reg;
    logic [7:0] gap_reg;
    logic [24:0] hist_reg;
    logic [9:0] win, rev;
    logic comma, lock_eff, sync_st, align_st;
    logic [18:0] an_cnt_reg;
    logic [19:0] quiet_cnt_reg, quiet_cyc;
    logic setup, hit, wr_en, rd_en;
    logic [13:0] idx;
    logic [31:0] rd_mux;
    logic tx_in_ready, tx_out_valid, tx_pop, can_load, tx_gate, in_pkt_reg;
    logic rx_in_ready, rx_out_valid, rx_push, rx_pop;
    sgm_tx_word_t tx_head;
    logic [9:0] rx_head;
    logic [4:0] tx_level, rx_level;
    logic [3:0] ferr_set;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        strap_s1_reg <= strap_rx_data;
        strap_s2_reg <= strap_s1_reg;
        lock_s1_reg <= cdr_lock_pin;
        lock_s2_reg <= lock_s1_reg;
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign setup = psel & ~penable;
    assign idx = paddr[15:2];
    assign hit = (paddr[1:0] == 2'h0) && (idx == `SGM_IDX_MAIN || idx == `SGM_IDX_EEE1 ||
        idx == `SGM_IDX_STAT || idx == `SGM_IDX_QUIET || idx == `SGM_IDX_CTRL2 || idx == `SGM_IDX_FERR);
    assign wr_en = psel & penable & pready & pwrite & hit;
    assign rd_en = psel & penable & pready & ~pwrite & hit;

    always_comb begin
        rd_mux = 32'h0;
        case (idx)
            `SGM_IDX_MAIN: rd_mux = {16'h0, main_reg};
            `SGM_IDX_EEE1: rd_mux = {16'h0, eee1_reg};
            `SGM_IDX_STAT: rd_mux = {19'h0, page_reg, serial_link_up, an_reg == AN_DONE,
                align_st, sync_st, sel_idx, 4'h0};
            `SGM_IDX_QUIET: rd_mux = {28'h0, quiet_reg};
            `SGM_IDX_CTRL2: rd_mux = {16'h0, ctrl2_reg[15:7], restart_reg, ctrl2_reg[5:0]};
            `SGM_IDX_FERR: rd_mux = {28'h0, ferr_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            prdata <= (setup & ~pwrite & hit) ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            main_reg <= `SGM_RST_MAIN;
            main_reg[`SGM_B_EN] <= strap_s2_reg == 3'h0;
            eee1_reg <= `SGM_RST_EEE1;
            quiet_reg <= `SGM_RST_QUIET;
            ctrl2_reg <= `SGM_RST_CTRL2;
        end else if (wr_en) begin
            if (idx == `SGM_IDX_MAIN) main_reg <= pwdata[15:0];
            if (idx == `SGM_IDX_EEE1) eee1_reg <= pwdata[15:0];
            if (idx == `SGM_IDX_QUIET) quiet_reg <= pwdata[3:0];
            if (idx == `SGM_IDX_CTRL2) ctrl2_reg <= {7'h0, pwdata[8:7], 1'b0, pwdata[5:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            restart_reg <= 1'b0;
        end else if (wr_en && idx == `SGM_IDX_CTRL2 && pwdata[`SGM_B_RESTART]) begin
            restart_reg <= 1'b1;
        end else begin
            restart_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Word boundary alignment
    // ----------------------------------------
    assign sel_idx = main_reg[`SGM_B_IFORCE] ? main_reg[`SGM_B_IVAL +: 4] : al_idx_reg;
    assign win = hist_reg[sel_idx +: 10];
    assign comma = win[6:0] == 7'h1F || win[6:0] == 7'h60;
    assign sync_st = al_reg == AL_SYNC;
    assign align_st = al_reg != AL_HUNT;

    always_ff @(posedge clk) begin
        if (reset) begin
            hist_reg <= 25'h0;
        end else if (des_rx_valid) begin
            hist_reg <= {hist_reg[14:0], des_rx_word ^ {10{main_reg[`SGM_B_RXINV]}}};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            al_reg <= AL_HUNT;
            al_idx_reg <= 4'h0;
            hits_reg <= 2'h0;
            gap_reg <= 8'h0;
        end else if (des_rx_valid) begin
            gap_reg <= comma ? 8'h0 : gap_reg + 8'h1;
            case (al_reg)
                AL_HUNT: begin
                    hits_reg <= 2'h1;
                    if (comma) begin
                        al_reg <= AL_CHECK;
                    end else begin
                        al_idx_reg <= (al_idx_reg == 4'h9) ? 4'h0 : al_idx_reg + 4'h1;
                    end
                end
                AL_CHECK: begin
                    if (gap_reg == `SGM_LOSS_WORDS) begin
                        al_reg <= AL_HUNT;
                    end else if (comma) begin
                        hits_reg <= hits_reg + 2'h1;
                        if (hits_reg == `SGM_SYNC_HITS - 2'h1) al_reg <= AL_SYNC;
                    end
                end
                AL_SYNC: begin
                    if (gap_reg == `SGM_LOSS_WORDS) al_reg <= AL_HUNT;
                end
                default: al_reg <= AL_HUNT;
            endcase
        end
    end

    // ----------------------------------------
    // Receive path toward the MAC
    // ----------------------------------------
    for (genvar i = 0; i < 10; i++) begin : g_rev
        assign rev[i] = main_reg[`SGM_B_RXORD] ? win[9-i] : win[i];
    end
    assign rx_push = des_rx_valid & sync_st & main_reg[`SGM_B_EN];
    assign rx_pop = rx_out_valid & (~mac_rx_valid | mac_rx_ready);

    sgm_fifo #(.W(10), .D(16)) u_rx_fifo (
        .clk(clk), .reset(reset), .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rev),
        .out_valid(rx_out_valid), .out_ready(rx_pop), .out_data(rx_head), .level(rx_level)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            mac_rx_valid <= 1'b0;
            mac_rx_word <= 10'h0;
        end else if (rx_pop) begin
            mac_rx_valid <= 1'b1;
            mac_rx_word <= rx_head;
        end else if (mac_rx_ready) begin
            mac_rx_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transmit path toward the serializer
    // ----------------------------------------
    assign can_load = ~ser_tx_valid | ser_tx_ready;
    assign tx_gate = ~(main_reg[`SGM_B_ALPKT] & tx_head.sop) | tx_even;
    assign tx_pop = tx_out_valid & can_load & tx_gate;

    sgm_fifo #(.W(11), .D(16)) u_tx_fifo (
        .clk(clk), .reset(reset), .in_valid(mac_tx_valid & mac_tx_ready), .in_ready(tx_in_ready),
        .in_data(mac_tx), .out_valid(tx_out_valid), .out_ready(tx_pop), .out_data(tx_head),
        .level(tx_level)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            mac_tx_ready <= 1'b0;
        end else begin
            mac_tx_ready <= main_reg[`SGM_B_EN] && tx_level < 5'hF;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ser_tx_valid <= 1'b0;
            ser_tx <= '0;
        end else if (tx_pop) begin
            ser_tx_valid <= 1'b1;
            ser_tx.sop <= tx_head.sop;
            ser_tx.eop <= tx_head.eop;
            ser_tx.err <= tx_head.err & ~main_reg[`SGM_B_TXERR];
            ser_tx.data <= tx_head.data ^ {8{main_reg[`SGM_B_TXINV]}};
        end else if (ser_tx_ready) begin
            ser_tx_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            in_pkt_reg <= 1'b0;
        end else if (tx_pop) begin
            in_pkt_reg <= (in_pkt_reg | tx_head.sop) & ~tx_head.eop;
        end
    end

    // ----------------------------------------
    // FIFO thresholds and error flags
    // ----------------------------------------
    assign ferr_set = {rx_push & ~rx_in_ready, mac_rx_ready & ~mac_rx_valid & ~rx_out_valid & sync_st,
        mac_tx_valid & ~tx_in_ready, in_pkt_reg & can_load & ~tx_out_valid};

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_fifo_half <= 1'b0;
            rx_fifo_half <= 1'b0;
            ferr_reg <= 4'h0;
        end else begin
            tx_fifo_half <= tx_level >= {2'h0, ctrl2_reg[`SGM_B_TXTH +: 3]};
            rx_fifo_half <= rx_level >= {2'h0, ctrl2_reg[`SGM_B_RXTH +: 3]};
            ferr_reg <= (rd_en && idx == `SGM_IDX_FERR) ? ferr_set : ferr_reg | ferr_set;
        end
    end

    // ----------------------------------------
    // Auto-negotiation and link
    // ----------------------------------------
    function automatic logic [18:0] an_cycles(input logic [1:0] code);
        case (code)
            2'h0: an_cycles = 19'(AN_T0_CYC);
            2'h1: an_cycles = 19'(AN_T1_CYC);
            2'h2: an_cycles = 19'(AN_T2_CYC);
            default: an_cycles = 19'(AN_T3_CYC);
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (reset || !main_reg[`SGM_B_ANEN] || !main_reg[`SGM_B_EN]) begin
            an_reg <= AN_OFF;
            an_cnt_reg <= 19'h0;
        end else if (restart_reg) begin
            an_reg <= AN_WAIT;
        end else begin
            case (an_reg)
                AN_OFF: an_reg <= AN_WAIT;
                AN_WAIT: begin
                    if (an_page_in) begin
                        an_reg <= AN_TIMER;
                        an_cnt_reg <= an_cycles(main_reg[`SGM_B_ANTIM +: 2]) - 19'h1;
                    end
                end
                AN_TIMER: begin
                    if (an_cnt_reg == 19'h0) an_reg <= AN_DONE;
                    else an_cnt_reg <= an_cnt_reg - 19'h1;
                end
                AN_DONE: an_reg <= AN_DONE;
                default: an_reg <= AN_OFF;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            page_reg <= 1'b0;
        end else if (an_page_in && an_reg != AN_OFF) begin
            page_reg <= 1'b1;
        end else if (rd_en && idx == `SGM_IDX_STAT) begin
            page_reg <= 1'b0;
        end
    end

    assign lock_eff = ctrl2_reg[`SGM_B_FCTL] ? ctrl2_reg[`SGM_B_FVAL] : lock_s2_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            serial_link_up <= 1'b0;
        end else begin
            serial_link_up <= main_reg[`SGM_B_EN] & lock_eff & sync_st &
                (~main_reg[`SGM_B_ANEN] | an_reg == AN_DONE);
        end
    end

    // ----------------------------------------
    // Low-power idle handling
    // ----------------------------------------
    assign quiet_cyc = 20'(QUIET_BASE_CYC) + 20'(QUIET_STEP_CYC) * {16'h0, quiet_reg};

    always_ff @(posedge clk) begin
        if (reset) begin
            quiet_cnt_reg <= 20'h0;
            rx_quiet_done <= 1'b0;
            rx_lpi_to_mac <= 1'b0;
        end else begin
            rx_lpi_to_mac <= rx_lpi_in & ~eee1_reg[`SGM_B_NONEEE];
            quiet_cnt_reg <= rx_lpi_in ? quiet_cnt_reg + 20'(!rx_quiet_done) : 20'h0;
            rx_quiet_done <= rx_lpi_in && (rx_quiet_done || quiet_cnt_reg + 20'h1 >= quiet_cyc);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_txerr;
        tx_pop && main_reg[`SGM_B_TXERR] |=> ser_tx_valid && !ser_tx.err;
    endproperty
    a_txerr: assert property (p_txerr) else $error("tx error passed");
    property p_force;
        main_reg[`SGM_B_IFORCE] |-> rd_mux[7:4] == main_reg[13:10] || idx != `SGM_IDX_STAT;
    endproperty
    a_force: assert property (p_force) else $error("forced index ignored");
    property p_strap;
        $fell(reset) |-> main_reg[`SGM_B_EN] == ($past(strap_s2_reg) == 3'h0);
    endproperty
    a_strap: assert property (disable iff (1'b0) p_strap) else $error("enable not from strap");
    property p_align;
        tx_pop && main_reg[`SGM_B_ALPKT] && tx_head.sop |-> tx_even;
    endproperty
    a_align: assert property (p_align) else $error("packet start off slot");
    property p_timer1;
        an_reg == AN_WAIT && an_page_in && main_reg[2:1] == 2'h1 && !restart_reg |=>
            (an_reg == AN_TIMER)[*8] ##[1:80] an_reg == AN_DONE;
    endproperty
    a_timer1: assert property (p_timer1) else $error("2us timer wrong");
    property p_anoff;
        !main_reg[`SGM_B_ANEN] |=> an_reg == AN_OFF;
    endproperty
    a_anoff: assert property (p_anoff) else $error("negotiation while disabled");
    property p_page;
        an_page_in && an_reg != AN_OFF |=> page_reg;
    endproperty
    a_page: assert property (p_page) else $error("page flag missed");
    property p_restart;
        restart_reg && main_reg[`SGM_B_ANEN] && main_reg[`SGM_B_EN] |=> !restart_reg && an_reg == AN_WAIT;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");
    property p_lockf;
        ctrl2_reg[`SGM_B_FCTL] && !ctrl2_reg[`SGM_B_FVAL] |=> !serial_link_up;
    endproperty
    a_lockf: assert property (p_lockf) else $error("forced lock ignored");
    property p_overfill;
        mac_tx_valid && !tx_in_ready |=> ferr_reg[1];
    endproperty
    a_overfill: assert property (p_overfill) else $error("tx overfill lost");
    c_sync: cover property (al_reg == AL_CHECK ##[1:40] al_reg == AL_SYNC);
    c_an: cover property (an_reg == AN_TIMER ##[1:100] an_reg == AN_DONE);
    c_pkt: cover property (tx_pop && tx_head.sop ##[1:20] tx_pop && tx_head.eop);
endmodule
`default_nettype wire

// >>> test/sgm_far_model.sv
// Serializer side model: slot pulse and ready with stalls
`timescale 1ns/10ps
`default_nettype none
module sgm_far_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    output logic ser_tx_ready,
    output logic tx_even
);
    logic [1:0] slot;
    always @(posedge clk) begin
        if (reset) begin
            slot <= 2'h0;
            ser_tx_ready <= 1'b0;
        end else begin
            slot <= slot + 2'h1;
            ser_tx_ready <= !stall && ($urandom % 4 != 0);
        end
    end
    // Even slot pulse every fourth cycle
    assign tx_even = (slot == 2'h0);
endmodule
`default_nettype wire

// >>> test/sgm_ctrl_tb.sv
// Testbench for the serial MAC interface control block
`include "sgm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module sgm_ctrl_tb;
    import sgm_pkg::*;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, stall = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, r, v;
    logic [2:0] strap_rx_data = 3'h0;
    sgm_tx_word_t mac_tx = '0, ser_tx, w, m, q[$];
    logic [9:0] des_rx_word = 10'h0, mac_rx_word;
    logic des_rx_valid = 0, mac_rx_ready = 1, cdr_lock_pin = 0, rx_lpi_in = 0, mac_rx_valid, rx_lpi_to_mac;
    logic rx_quiet_done, tx_fifo_half, rx_fifo_half, serial_link_up;
    logic mac_tx_valid = 0, mac_tx_ready, ser_tx_valid, ser_tx_ready, tx_even, an_page_in = 0, e, inv = 0;
    int num_errors = 0, comparisons = 0, n, i, p;
    sgm_ctrl #(.AN_T0_CYC(200), .AN_T2_CYC(100), .AN_T3_CYC(300), .QUIET_BASE_CYC(50)) i_sgm_ctrl (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_rx_data(strap_rx_data),
        .mac_tx(mac_tx), .mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready), .ser_tx(ser_tx),
        .ser_tx_valid(ser_tx_valid), .ser_tx_ready(ser_tx_ready), .tx_even(tx_even),
        .des_rx_word(des_rx_word), .des_rx_valid(des_rx_valid), .mac_rx_word(mac_rx_word),
        .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready), .an_page_in(an_page_in),
        .cdr_lock_pin(cdr_lock_pin), .rx_lpi_in(rx_lpi_in), .rx_lpi_to_mac(rx_lpi_to_mac),
        .rx_quiet_done(rx_quiet_done), .tx_fifo_half(tx_fifo_half), .rx_fifo_half(rx_fifo_half),
        .serial_link_up(serial_link_up));
    sgm_far_model i_sgm_far_model (.clk(clk), .reset(reset), .stall(stall), .ser_tx_ready(ser_tx_ready),
        .tx_even(tx_even));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic close_out;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [1:0] lo, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge clk);
        end
        if (k == 50)
            num_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset(input logic [2:0] s);
        reset <= 1'b1;
        strap_rx_data <= s;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    // Model of the transmit path
    function automatic sgm_tx_word_t xf(input sgm_tx_word_t x);
        xf = x;
        xf.err = 1'b0;
        if (inv)
            xf.data = ~x.data;
    endfunction
    always @(posedge clk) begin
        if (!reset && ser_tx_valid === 1'b1 && ser_tx_ready === 1'b1) begin
            if (q.size() == 0) begin
                `CHK("ser_tx_extra", 1'b0, 1'b1)
            end else begin
                m = q.pop_front();
                `CHK("ser_tx", m, ser_tx)
            end
        end
    end
    initial begin
        #(25 * 40000);
        num_errors++;
        close_out();
    end
    initial begin
        void'($urandom(32'hdf07));
        do_reset(3'h0);
        apb(0, `SGM_IDX_MAIN, 2'h0, 0);
        `CHK("main_rst", 32'h0000027B, r)
        apb(0, `SGM_IDX_QUIET, 2'h0, 0);
        `CHK("quiet_rst", 32'h00000005, r)
        apb(0, `SGM_IDX_CTRL2, 2'h0, 0);
        `CHK("ctrl2_rst", 32'h00000024, r)
        apb(0, `SGM_IDX_FERR, 2'h0, 0);
        `CHK("ferr_rst", 32'h00000000, r)
        apb(0, 14'h060E, 2'h0, 0);
        `CHK("unmapped", 33'h100000000, {e, r})
        apb(1, `SGM_IDX_MAIN, 2'h1, 32'h00000000);
        `CHK("misaligned", 1'b1, e)
        v = $urandom & 32'hFFFF;
        apb(1, `SGM_IDX_EEE1, 2'h0, v);
        apb(0, `SGM_IDX_EEE1, 2'h0, 0);
        `CHK("eee1", v, r)
        apb(1, `SGM_IDX_CTRL2, 2'h0, 32'h000000D9);
        apb(0, `SGM_IDX_CTRL2, 2'h0, 0);
        `CHK("restart_clr", 32'h00000099, r)
        an_page_in <= 1'b1;
        @(posedge clk);
        an_page_in <= 1'b0;
        apb(0, `SGM_IDX_STAT, 2'h0, 0);
        `CHK("page_set", 1'b1, r[12])
        apb(0, `SGM_IDX_STAT, 2'h0, 0);
        `CHK("page_clr", 1'b0, r[12])
        for (p = 0; p < 2; p++) begin
            inv = p[0];
            apb(1, `SGM_IDX_MAIN, 2'h0, p ? 32'h000082FB : 32'h0000827B);
            for (i = 0; i < 6; i++) begin
                w = '{sop: i == 0, eop: i == 5, err: 1'b1, data: 8'($urandom)};
                q.push_back(xf(w));
                mac_tx <= w;
                mac_tx_valid <= 1'b1;
                n = 0;
                @(posedge clk);
                while (mac_tx_ready !== 1'b1 && n < 200) begin
                    n++;
                    @(posedge clk);
                end
            end
            mac_tx_valid <= 1'b0;
            repeat (60) @(posedge clk);
            `CHK("pkt_drained", 0, q.size())
        end
        stall <= 1'b1;
        repeat (3) @(posedge clk);
        w = '{sop: 1'b0, eop: 1'b0, err: 1'b1, data: 8'($urandom)};
        mac_tx <= w;
        mac_tx_valid <= 1'b1;
        for (i = 0; i < 30; i++) begin
            @(posedge clk);
            if (mac_tx_ready === 1'b1) begin
                q.push_back(xf(w));
                w = '{sop: 1'b0, eop: 1'b0, err: 1'b1, data: 8'($urandom)};
                mac_tx <= w;
            end
        end
        `CHK("refused", 1'b0, mac_tx_ready)
        mac_tx_valid <= 1'b0;
        apb(0, `SGM_IDX_FERR, 2'h0, 0);
        `CHK("tx_overfill", 1'b1, r[1])
        stall <= 1'b0;
        repeat (150) @(posedge clk);
        `CHK("fifo_drained", 0, q.size())
        // Receive stream with forced boundary zero, MAC stalled
        cdr_lock_pin <= 1'b1;
        apb(1, `SGM_IDX_CTRL2, 2'h0, 32'h00000024);
        apb(1, `SGM_IDX_MAIN, 2'h0, 32'h0000C2FB);
        mac_rx_ready <= 1'b0;
        des_rx_word <= 10'h01F;
        des_rx_valid <= 1'b1;
        repeat (40) @(posedge clk);
        `CHK("rx_held", 11'h7E0, {mac_rx_valid, mac_rx_word})
        `CHK("fifo_half", 2'h2, {rx_fifo_half, tx_fifo_half})
        `CHK("link_up", 1'b1, serial_link_up)
        mac_rx_ready <= 1'b1;
        des_rx_valid <= 1'b0;
        repeat (30) @(posedge clk);
        apb(0, `SGM_IDX_FERR, 2'h0, 0);
        `CHK("rx_flags", 4'hC, r[3:0])
        apb(0, `SGM_IDX_STAT, 2'h0, 0);
        `CHK("status", 9'h0F0, r[12:4])
        // Receive quiet timer at code zero
        apb(1, `SGM_IDX_QUIET, 2'h0, 0);
        rx_lpi_in <= 1'b1;
        repeat (45) @(posedge clk);
        `CHK("lpi_mac", !v[0], rx_lpi_to_mac)
        `CHK("quiet_early", 1'b0, rx_quiet_done)
        repeat (10) @(posedge clk);
        `CHK("quiet_done", 1'b1, rx_quiet_done)
        rx_lpi_in <= 1'b0;
        apb(1, `SGM_IDX_MAIN, 2'h0, 32'h0000007B);
        repeat (3) @(posedge clk);
        `CHK("disabled", 1'b0, mac_tx_ready)
        `CHK("link_down", 1'b0, serial_link_up)
        do_reset(3'h2);
        apb(0, `SGM_IDX_MAIN, 2'h0, 0);
        `CHK("main_strap", 32'h0000007B, r)
        close_out();
    end
endmodule
`default_nettype wire
